//--- pkg/spr_pkg.sv
// Constants and types for the serial pin router
// Functional notes
// - First group: channel 1 unmuxed pins, or layer-1 port in IDL, GCI, PCM.
// - Layer-1 transmit is always driven in IDL, three-state in PCM, open-drain in GCI, optional in unmuxed.
// - Unmuxed channel 1 clock pins: inputs on external clock, baud outputs on internal.
// - Channel 1 clock pins drive baud clock until the clock-out enable clears.
// - Channel 2 clock pin outputs are gated by the port A control setting when channel 2 is unmuxed.
// - PCM sync code 00 idles transmit and ignores receive; 01,10,11 pick channels.
// - Each PCM channel is routed to a serial channel by mode configuration.
// - Data strobes assert in B1 and/or B2 windows per mask configuration.
// - Carrier detect change held over one receive clock sets its event bit.
// - Carrier detect level is readable; without auto use it is a plain event.
// - Clear-to-send change held over one transmit clock sets event, may abort.
// - Clear-to-send level is readable; without support it is a plain event.
// - Unmuxed request-to-send asserts low while channel 1 has data or pad.
// - PCM request-to-send is active high.
// - Request-to-send pin carries layer-1 request in IDL, data clock in GCI.
// - Each port A pin is general purpose or channel 2 function.
// - Port A pin 7 gives strobe 2 in IDL/GCI; with channel 2 unmuxed, strobe 2 if enabled, else channel 2 baud clock.
// - Port A pin 7 as general output overrides strobe 2 or baud clock.
// - Channel 2 transmit clock pin carries its baud clock when multiplexed.
// - Port A pin 7 low at reset release enables boot from channel 2.
// - In boot mode port A pin 5 picks channel 2 clock, sampled late.
// - Multiplexed layer-1 port serves both serial channels at once.
package spr_pkg;
  typedef enum logic [1:0] {SPR_UNMUX, SPR_IDL, SPR_GCI, SPR_PCM} spr_mode_e;
  typedef enum logic [1:0] {SPR_BT_SYNC, SPR_BT_HOLD, SPR_BT_DONE} spr_boot_e;
  // ****************************************
  // Register map
  // ****************************************
  localparam int          ADR_W     = 8;
  localparam int          DAT_W     = 32;
  localparam logic [7:0]  ADR_MODE  = 8'h00;
  localparam logic [7:0]  ADR_PORTA = 8'h04;
  localparam logic [7:0]  ADR_STAT  = 8'h08;
  localparam int          MODE_W    = 19;
  localparam int          PA_W      = 26;
  localparam logic [18:0] MODE_RST  = 19'h00000;
  localparam logic [25:0] PA_RST    = 26'h0000000;
  // Mode register fields
  localparam int MD_LSB = 0, TXD_OD_BIT = 2, CH1_INT_BIT = 3, CLKOUT_BIT = 4;
  localparam int CD_AUTO_BIT = 5, CTS_AUTO_BIT = 6, ABORT_BIT = 7;
  localparam int S1EN_LSB = 8, S2EN_LSB = 10, RT1_LSB = 12, RT2_LSB = 14, RT3_LSB = 16;
  localparam int CH2_UNMUX_BIT = 18;
  // Port A register fields
  localparam int DED_LSB = 0, DIR_LSB = 8, DAT_LSB = 16, CH2_CLKOE_BIT = 24, CH2_INT_BIT = 25;
  // Status register fields
  localparam int ST_CD = 0, ST_CTS = 1, ST_CD_EVT = 2, ST_CTS_EVT = 3;
  localparam int ST_BOOT = 4, ST_BOOT_CLK = 5, ST_PA_LSB = 8;
  // PCM channel routing codes
  localparam logic [1:0] RT_NONE = 2'h0, RT_CH1 = 2'h1, RT_CH2 = 2'h2;
  // Port A pin functions
  localparam int PA_RXD = 0, PA_TXD = 1, PA_RCLK = 2, PA_TCLK = 3;
  localparam int PA_RTS = 5, PA_BOOT_CLK = 5, PA_BOOT = 7;
  // Synchroniser slots
  localparam int SY_RXD = 0, SY_RCLK = 1, SY_TCLK = 2, SY_CD = 3, SY_CTS = 4, SY_PA = 5;
  localparam int SY_W = 13;
  localparam logic [12:0] SY_RST = 13'h1fff;
  localparam logic [1:0]  STAB_RST = 2'h3;
  // Boot strap timing, in system clocks
  localparam logic [6:0] SYNC_LAT       = 7'd2;
  localparam logic [6:0] BOOT_HOLD_CLKS = 7'd100;
  localparam logic [6:0] BOOT_SMP_CLKS  = BOOT_HOLD_CLKS - SYNC_LAT - 7'd1;
endpackage

//--- rtl/spr_pin_router.sv
// Pin routing for the layer-1 serial interface and port A
module spr_pin_router (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [spr_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [spr_pkg::DAT_W-1:0]   wb_dat_i,
  output logic      [spr_pkg::DAT_W-1:0]   wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        ch1_tx_data_i,
  input  wire logic                        ch2_tx_data_i,
  input  wire logic                        ch1_tx_pending_i,
  input  wire logic                        ch2_tx_pending_i,
  input  wire logic                        ch1_baud_clk_i,
  input  wire logic                        ch2_baud_clk_i,
  input  wire logic                        layer1_request_i,
  input  wire logic                        gci_data_clock_i,
  input  wire logic                        b1_window_i,
  input  wire logic                        b2_window_i,
  output logic                             ch1_rx_data_o,
  output logic                             ch2_rx_data_o,
  output logic                             ch1_carrier_o,
  output logic                             ch1_cts_o,
  output logic                             ch1_tx_abort_o,
  output logic                             boot_serial_o,
  output logic                             boot_clk_sel_o,
  input  wire logic                        layer1_rx_data_i,
  output logic                             layer1_tx_data_o,
  output logic                             layer1_tx_data_oe_o,
  input  wire logic                        layer1_clock_i,
  output logic                             layer1_clock_o,
  output logic                             layer1_clock_oe_o,
  input  wire logic                        ch1_tx_clock_i,
  output logic                             ch1_tx_clock_o,
  output logic                             ch1_tx_clock_oe_o,
  input  wire logic                        ch1_carrier_detect_i,
  input  wire logic                        ch1_clear_to_send_i,
  output logic                             ch1_request_to_send_o,
  input  wire logic [7:0]                  port_a_i,
  output logic      [7:0]                  port_a_o,
  output logic      [7:0]                  port_a_oe_o
);
  import spr_pkg::*;

  logic [SY_W-1:0]   meta_r, sync_r;
  logic [MODE_W-1:0] mode_r, mode_nxt;
  logic [PA_W-1:0]   pa_r, pa_nxt;
  logic [DAT_W-1:0]  dat_r, dat_nxt, wmask, mode_w, pa_w, stat;
  logic              ack_r, ack_nxt, wr, rd;
  logic              cd_evt_r, cd_evt_nxt, cts_evt_r, cts_evt_nxt;
  logic [1:0]        lc_prev_r, stab_r, pend_r, lc_nxt, stab_nxt, pend_nxt, evt, lclk, sig;
  spr_mode_e         mode;
  spr_boot_e         bt_r, bt_nxt;
  logic [6:0]        bcnt_r, bcnt_nxt;
  logic              boot_r, boot_nxt, bclk_r, bclk_nxt;
  logic              rxd_s, rclk_s, tclk_s, cd_s, cts_s;
  logic [7:0]        pa_s, ded, dir, gpd, fn_o, fn_oe, pa_o_nxt, pa_oe_nxt;
  logic [1:0]        code, route;
  logic              strobe1, strobe2, bwin, clk_out, txd, txd_od, txd_en, ch2_unmux;
  logic              rx1, rx2, rts, tck_o, tck_oe, txd_o_nxt, txd_oe_nxt, rck_oe;
  logic              abort_nxt, cd_o_nxt, cts_o_nxt;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= SY_RST;
      sync_r <= SY_RST;
    end
    else
    begin
      meta_r <= {port_a_i, ch1_clear_to_send_i, ch1_carrier_detect_i, ch1_tx_clock_i,
                 layer1_clock_i, layer1_rx_data_i};
      sync_r <= meta_r;
    end
  end

  assign rxd_s  = sync_r[SY_RXD];
  assign rclk_s = sync_r[SY_RCLK];
  assign tclk_s = sync_r[SY_TCLK];
  assign cd_s   = sync_r[SY_CD];
  assign cts_s  = sync_r[SY_CTS];
  assign pa_s   = sync_r[SY_PA +: 8];
  assign mode   = spr_mode_e'(mode_r[MD_LSB +: 2]);
  assign ded    = pa_r[DED_LSB +: 8];
  assign dir    = pa_r[DIR_LSB +: 8];
  assign gpd    = pa_r[DAT_LSB +: 8];
  assign ch2_unmux = mode_r[CH2_UNMUX_BIT];

  // ****************************************
  // Carrier and clear-to-send change detect
  // ****************************************
  always_comb
  begin
    // Link clock edges found by the system clock
    lclk[0] = mode_r[CH1_INT_BIT] ? ch1_baud_clk_i : rclk_s;
    lclk[1] = mode_r[CH1_INT_BIT] ? ch1_baud_clk_i : tclk_s;
    sig      = {cts_s, cd_s};
    lc_nxt   = lclk;
    stab_nxt = stab_r;
    pend_nxt = pend_r;
    evt      = 2'b00;
    for (int i = 0; i < 2; i++)
    begin
      if (lclk[i] && !lc_prev_r[i])
      begin
        if (sig[i] == stab_r[i])
          pend_nxt[i] = 1'b0;
        else if (pend_r[i])
        begin
          // New level seen on two link edges
          stab_nxt[i] = sig[i];
          pend_nxt[i] = 1'b0;
          evt[i]      = 1'b1;
        end
        else
          pend_nxt[i] = 1'b1;
      end
    end
    cd_o_nxt  = mode_r[CD_AUTO_BIT] & ~stab_r[0];
    cts_o_nxt = ~mode_r[CTS_AUTO_BIT] | ~stab_r[1];
    abort_nxt = evt[1] & mode_r[CTS_AUTO_BIT] & mode_r[ABORT_BIT] & ch1_tx_pending_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lc_prev_r      <= 2'b00;
      stab_r         <= STAB_RST;
      pend_r         <= 2'b00;
      ch1_carrier_o  <= 1'b0;
      ch1_cts_o      <= 1'b1;
      ch1_tx_abort_o <= 1'b0;
    end
    else
    begin
      lc_prev_r      <= lc_nxt;
      stab_r         <= stab_nxt;
      pend_r         <= pend_nxt;
      ch1_carrier_o  <= cd_o_nxt;
      ch1_cts_o      <= cts_o_nxt;
      ch1_tx_abort_o <= abort_nxt;
    end
  end

  // ****************************************
  // Boot strap capture
  // ****************************************
  always_comb
  begin
    bt_nxt   = bt_r;
    bcnt_nxt = bcnt_r + 7'd1;
    boot_nxt = boot_r;
    bclk_nxt = bclk_r;
    case (bt_r)
      SPR_BT_SYNC:
      begin
        if (bcnt_r == SYNC_LAT)
        begin
          boot_nxt = ~pa_s[PA_BOOT];
          bt_nxt   = SPR_BT_HOLD;
        end
      end
      SPR_BT_HOLD:
      begin
        if (!boot_r)
          bt_nxt = SPR_BT_DONE;
        else if (bcnt_r == BOOT_SMP_CLKS)
        begin
          bclk_nxt = pa_s[PA_BOOT_CLK];
          bt_nxt   = SPR_BT_DONE;
        end
      end
      SPR_BT_DONE:
        bcnt_nxt = bcnt_r;
      default:
        bt_nxt = SPR_BT_DONE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bt_r   <= SPR_BT_SYNC;
      bcnt_r <= 7'd0;
      boot_r <= 1'b0;
      bclk_r <= 1'b0;
    end
    else
    begin
      bt_r   <= bt_nxt;
      bcnt_r <= bcnt_nxt;
      boot_r <= boot_nxt;
      bclk_r <= bclk_nxt;
    end
  end

  assign boot_serial_o  = boot_r;
  assign boot_clk_sel_o = bclk_r;

  // ****************************************
  // Pin multiplexing
  // ****************************************
  always_comb
  begin
    code = {cd_s, tclk_s};
    case (code)
      2'b01:   route = mode_r[RT1_LSB +: 2];
      2'b10:   route = mode_r[RT2_LSB +: 2];
      2'b11:   route = mode_r[RT3_LSB +: 2];
      default: route = RT_NONE;
    endcase
    bwin    = b1_window_i | b2_window_i;
    strobe1 = (mode_r[S1EN_LSB] & b1_window_i) | (mode_r[S1EN_LSB+1] & b2_window_i);
    strobe2 = (mode_r[S2EN_LSB] & b1_window_i) | (mode_r[S2EN_LSB+1] & b2_window_i);
    clk_out = (mode == SPR_UNMUX) & mode_r[CH1_INT_BIT] & mode_r[CLKOUT_BIT];
    rck_oe  = clk_out;
    tck_o   = ch1_baud_clk_i;
    tck_oe  = clk_out;
    txd     = ch1_tx_data_i;
    txd_od  = 1'b0;
    txd_en  = 1'b1;
    rx1     = rxd_s;
    rx2     = ch2_unmux ? pa_s[PA_RXD] : rxd_s;
    rts     = ~ch1_tx_pending_i;
    case (mode)
      SPR_UNMUX:
        txd_od = mode_r[TXD_OD_BIT];
      SPR_IDL, SPR_GCI:
      begin
        txd    = bwin ? ch2_tx_data_i : ch1_tx_data_i;
        txd_od = (mode == SPR_GCI);
        tck_o  = strobe1;
        tck_oe = 1'b1;
        rts    = (mode == SPR_GCI) ? gci_data_clock_i : layer1_request_i;
      end
      SPR_PCM:
      begin
        txd    = (route == RT_CH2) ? ch2_tx_data_i : ch1_tx_data_i;
        txd_en = (route == RT_CH1) | (route == RT_CH2);
        tck_oe = 1'b0;
        rx1    = (route == RT_CH1) ? rxd_s : 1'b1;
        if (!ch2_unmux)
          rx2 = (route == RT_CH2) ? rxd_s : 1'b1;
        rts    = ch1_tx_pending_i;
      end
      default:
        txd_en = 1'b0;
    endcase
    txd_o_nxt  = txd & ~txd_od;
    txd_oe_nxt = txd_en & (~txd_od | ~txd);
    fn_o  = 8'h00;
    fn_oe = 8'h00;
    fn_o[PA_TXD]   = ch2_tx_data_i;
    fn_oe[PA_TXD]  = 1'b1;
    fn_o[PA_RCLK]  = ch2_baud_clk_i;
    fn_oe[PA_RCLK] = ch2_unmux & pa_r[CH2_INT_BIT] & pa_r[CH2_CLKOE_BIT];
    fn_o[PA_TCLK]  = ch2_baud_clk_i;
    fn_oe[PA_TCLK] = ~ch2_unmux | (pa_r[CH2_INT_BIT] & pa_r[CH2_CLKOE_BIT]);
    fn_o[PA_RTS]   = ~ch2_tx_pending_i;
    fn_oe[PA_RTS]  = 1'b1;
    if (mode == SPR_IDL || mode == SPR_GCI)
    begin
      fn_o[PA_BOOT]  = strobe2;
      fn_oe[PA_BOOT] = 1'b1;
    end
    else if (ch2_unmux)
    begin
      fn_o[PA_BOOT]  = (mode_r[S2EN_LSB +: 2] != 2'b00) ? strobe2 : ch2_baud_clk_i;
      fn_oe[PA_BOOT] = 1'b1;
    end
    pa_o_nxt  = (ded & fn_o) | (~ded & gpd);
    pa_oe_nxt = (ded & fn_oe) | (~ded & dir);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      layer1_tx_data_o      <= 1'b1;
      layer1_tx_data_oe_o   <= 1'b0;
      layer1_clock_o        <= 1'b0;
      layer1_clock_oe_o     <= 1'b0;
      ch1_tx_clock_o        <= 1'b0;
      ch1_tx_clock_oe_o     <= 1'b0;
      ch1_request_to_send_o <= 1'b1;
      ch1_rx_data_o         <= 1'b1;
      ch2_rx_data_o         <= 1'b1;
      port_a_o              <= 8'h00;
      port_a_oe_o           <= 8'h00;
    end
    else
    begin
      layer1_tx_data_o      <= txd_o_nxt;
      layer1_tx_data_oe_o   <= txd_oe_nxt;
      layer1_clock_o        <= ch1_baud_clk_i;
      layer1_clock_oe_o     <= rck_oe;
      ch1_tx_clock_o        <= tck_o;
      ch1_tx_clock_oe_o     <= tck_oe;
      ch1_request_to_send_o <= rts;
      ch1_rx_data_o         <= rx1;
      ch2_rx_data_o         <= rx2;
      port_a_o              <= pa_o_nxt;
      port_a_oe_o           <= pa_oe_nxt;
    end
  end

  // ****************************************
  // Wishbone register slave
  // ****************************************
  always_comb
  begin
    wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // Write lands at the edge where the master sees ack high
    wr     = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    rd     = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r;
    mode_w = ({{(DAT_W-MODE_W){1'b0}}, mode_r} & ~wmask) | (wb_dat_i & wmask);
    pa_w   = ({{(DAT_W-PA_W){1'b0}}, pa_r} & ~wmask) | (wb_dat_i & wmask);
    stat   = '0;
    stat[ST_CD]              = stab_r[0];
    stat[ST_CTS]             = stab_r[1];
    stat[ST_CD_EVT]          = cd_evt_r;
    stat[ST_CTS_EVT]         = cts_evt_r;
    stat[ST_BOOT]            = boot_r;
    stat[ST_BOOT_CLK]        = bclk_r;
    stat[ST_PA_LSB +: 8]     = pa_s;
    ack_nxt     = wb_cyc_i & wb_stb_i & ~ack_r;
    mode_nxt    = mode_r;
    pa_nxt      = pa_r;
    cd_evt_nxt  = cd_evt_r;
    cts_evt_nxt = cts_evt_r;
    dat_nxt     = dat_r;
    if (wr)
    begin
      case (wb_adr_i)
        ADR_MODE:  mode_nxt = mode_w[MODE_W-1:0];
        ADR_PORTA: pa_nxt = pa_w[PA_W-1:0];
        ADR_STAT:
        begin
          cd_evt_nxt  = cd_evt_r & ~(wb_dat_i[ST_CD_EVT] & wmask[ST_CD_EVT]);
          cts_evt_nxt = cts_evt_r & ~(wb_dat_i[ST_CTS_EVT] & wmask[ST_CTS_EVT]);
        end
        default:   mode_nxt = mode_r;
      endcase
    end
    // Set wins over a clear in the same cycle
    cd_evt_nxt  = cd_evt_nxt | evt[0];
    cts_evt_nxt = cts_evt_nxt | evt[1];
    if (rd)
    begin
      case (wb_adr_i)
        ADR_MODE:  dat_nxt = {{(DAT_W-MODE_W){1'b0}}, mode_r};
        ADR_PORTA: dat_nxt = {{(DAT_W-PA_W){1'b0}}, pa_r};
        ADR_STAT:  dat_nxt = stat;
        default:   dat_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r    <= MODE_RST;
      pa_r      <= PA_RST;
      cd_evt_r  <= 1'b0;
      cts_evt_r <= 1'b0;
      ack_r     <= 1'b0;
      dat_r     <= '0;
    end
    else
    begin
      mode_r    <= mode_nxt;
      pa_r      <= pa_nxt;
      cd_evt_r  <= cd_evt_nxt;
      cts_evt_r <= cts_evt_nxt;
      ack_r     <= ack_nxt;
      dat_r     <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ****************************************
  // Checks
  // ****************************************
  chk_pcm_idle_tx: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == SPR_PCM && code == 2'b00) |=> !layer1_tx_data_oe_o)
    else $error("PCM idle code left transmit driven");
  chk_gci_open_drain: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(mode) == SPR_GCI && layer1_tx_data_oe_o) |-> !layer1_tx_data_o)
    else $error("GCI transmit drove high");
  chk_ext_clk_input: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == SPR_UNMUX && !mode_r[CH1_INT_BIT]) |=> !layer1_clock_oe_o && !ch1_tx_clock_oe_o)
    else $error("Clock pin driven on external clock");
  chk_clk_out_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == SPR_UNMUX && mode_r[CH1_INT_BIT]) |=> layer1_clock_oe_o == $past(mode_r[CLKOUT_BIT]))
    else $error("Clock output enable mismatch");
  chk_rts_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == SPR_PCM || mode == SPR_UNMUX) |=>
      ch1_request_to_send_o == ($past(ch1_tx_pending_i) ^ ($past(mode) == SPR_UNMUX)))
    else $error("Request-to-send polarity wrong");
  chk_gci_dclk: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == SPR_GCI |=> ch1_request_to_send_o == $past(gci_data_clock_i))
    else $error("GCI data clock not on request pin");
  chk_pa7_gp_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ded[PA_BOOT] && dir[PA_BOOT]) |=>
      port_a_oe_o[PA_BOOT] && port_a_o[PA_BOOT] == $past(gpd[PA_BOOT]))
    else $error("Port A pin 7 general output overridden");
  chk_ch2_tx_clock_brg: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ch2_unmux && ded[PA_TCLK]) |=>
      port_a_oe_o[PA_TCLK] && port_a_o[PA_TCLK] == $past(ch2_baud_clk_i))
    else $error("Channel 2 transmit clock lacks baud clock");
  chk_cd_evt_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    evt[0] ##1 !(wr && wb_adr_i == ADR_STAT) |-> cd_evt_r [*2])
    else $error("Carrier event not held");
endmodule

//--- sim/spr_l1_partner.sv
// Layer-1 partner model: link clock, sync code, carrier and grant pins
module spr_l1_partner (
  input  wire logic       run_i,
  input  wire logic [1:0] code_i,
  input  wire logic       cd_n_i,
  input  wire logic       cts_n_i,
  output logic            clk_o,
  output logic            rxd_o,
  output logic            sync0_o,
  output logic            sync1_o,
  output logic            grant_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial clk_o = 1'b0;
  // Link clock stands still outside frames
  always
  begin
    #80;
    if (run_i)
      clk_o = ~clk_o;
  end
  assign rxd_o   = ~clk_o;
  assign sync0_o = run_i ? clk_o : code_i[0];
  assign sync1_o = run_i ? cd_n_i : code_i[1];
  // Grant stays high unless a test pulls it
  assign grant_o = cts_n_i;
endmodule

//--- sim/spr_pin_router_bench.sv
// Self-checking bench for the serial pin router
module spr_pin_router_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import spr_pkg::*;
  typedef struct packed {logic [31:0] mode; logic [4:0] io;} spr_row_s;
  // io: pending, tx data, request pin, tx enable, clock pin enable
  spr_row_s rows [10] = '{'{32'h00, 5'b11010}, '{32'h00, 5'b01110}, '{32'h04, 5'b01100},
    '{32'h18, 5'b00111}, '{32'h08, 5'b00110}, '{32'h01, 5'b01010}, '{32'h02, 5'b01100},
    '{32'h02, 5'b00110}, '{32'h03, 5'b11100}, '{32'h03, 5'b01000}};
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00, pa_ext = 8'h20;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic        c1tx = 1'b0, c2tx = 1'b0, pend = 1'b0, b1 = 1'b0, l1req = 1'b0;
  logic        gclk = 1'b1, bd1 = 1'b0, bd2 = 1'b0, run = 1'b0, cd_n = 1'b1, cts_n = 1'b1;
  logic [1:0]  code = 2'h0;
  logic        ack, p_clk, p_rxd, p_s0, p_s1, p_gr, lk_w, tk_w;
  logic        l1tx, l1txoe, lk_o, lk_oe, tk_o, tk_oe, rts, car, cts;
  logic        rx1o, rx2o, abort;
  logic [7:0]  pa_o, pa_oe, pa_w;
  int          n_errors = 0, cmp_count = 0, n_abort = 0;
  assign lk_w = lk_oe ? lk_o : p_clk;
  assign tk_w = tk_oe ? tk_o : p_s0;
  assign pa_w = (pa_o & pa_oe) | (pa_ext & ~pa_oe);
  always #10 clk_i = ~clk_i;
  // Abort pulses seen on the channel 1 transmitter
  always @(posedge clk_i)
    if (abort === 1'b1)
      n_abort++;
  spr_l1_partner partner (.run_i(run), .code_i(code), .cd_n_i(cd_n), .cts_n_i(cts_n),
    .clk_o(p_clk), .rxd_o(p_rxd), .sync0_o(p_s0), .sync1_o(p_s1), .grant_o(p_gr));
  spr_pin_router dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ch1_tx_data_i(c1tx), .ch2_tx_data_i(c2tx), .ch1_tx_pending_i(pend),
    .ch2_tx_pending_i(1'b0), .ch1_baud_clk_i(bd1), .ch2_baud_clk_i(bd2),
    .layer1_request_i(l1req), .gci_data_clock_i(gclk), .b1_window_i(b1),
    .b2_window_i(1'b0), .ch1_rx_data_o(rx1o), .ch2_rx_data_o(rx2o), .ch1_carrier_o(car),
    .ch1_cts_o(cts), .ch1_tx_abort_o(abort), .boot_serial_o(), .boot_clk_sel_o(),
    .layer1_rx_data_i(p_rxd), .layer1_tx_data_o(l1tx), .layer1_tx_data_oe_o(l1txoe),
    .layer1_clock_i(lk_w), .layer1_clock_o(lk_o), .layer1_clock_oe_o(lk_oe),
    .ch1_tx_clock_i(tk_w), .ch1_tx_clock_o(tk_o), .ch1_tx_clock_oe_o(tk_oe),
    .ch1_carrier_detect_i(p_s1), .ch1_clear_to_send_i(p_gr),
    .ch1_request_to_send_o(rts), .port_a_i(pa_w), .port_a_o(pa_o), .port_a_oe_o(pa_oe));
  // ****************************************
  // Helpers
  // ****************************************
  // ****************************************
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    for (i = 0; i < 16 && ack !== 1'b1; i++)
      @(posedge clk_i);
    chk(ack, 32'h1);
    if (ack !== 1'b1)
      final_report();
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({pa_oe, l1txoe, lk_oe, tk_oe, rts, cts}, {8'h00, 5'b00011});
    idle(110);
    chk({dut.boot_serial_o, dut.boot_clk_sel_o}, 2'b11);
    wb(1'b0, ADR_MODE, 32'h0, 4'h0);
    chk(rd, 32'(MODE_RST));
    $display("test reset_boot done");
    foreach (rows[k])
    begin
      wb(1'b1, ADR_MODE, rows[k].mode, 4'hf);
      pend <= rows[k].io[4];
      c1tx <= rows[k].io[3];
      idle(4);
      chk(rts, rows[k].io[2]);
      chk(l1txoe, rows[k].io[1]);
      chk(lk_oe, rows[k].io[0]);
    end
    $display("test mode_table done");
    wb(1'b1, ADR_MODE, 32'h9003, 4'hf);
    c2tx <= 1'b1;
    c1tx <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk_i);
      code <= c[1:0];
      idle(4);
      chk(l1txoe, (c == 1 || c == 2));
      chk({rx1o, rx2o}, 2'b11);
      if (l1txoe === 1'b1)
        chk(l1tx, (c == 2));
    end
    wb(1'b0, ADR_MODE, 32'h0, 4'h0);
    chk(rd, 32'h9003);
    wb(1'b0, 8'h0c, 32'h0, 4'h0);
    chk(rd, 32'h0);
    $display("test pcm_route done");
    wb(1'b1, ADR_MODE, 32'h501, 4'hf);
    wb(1'b1, ADR_PORTA, 32'h0100_0088, 4'hf);
    b1 <= 1'b1;
    bd2 <= 1'b1;
    idle(4);
    chk({tk_oe, tk_o, pa_oe[7], pa_o[7], pa_oe[3], pa_o[3]}, 32'h3f);
    @(posedge clk_i);
    b1 <= 1'b0;
    bd2 <= 1'b0;
    idle(4);
    chk({tk_o, pa_o[7], pa_o[3]}, 32'h0);
    wb(1'b1, ADR_PORTA, 32'h0005_8f00, 4'hf);
    b1 <= 1'b1;
    pa_ext <= 8'h50;
    idle(4);
    chk({pa_oe, pa_o & 8'h8f}, 32'h8f05);
    wb(1'b0, ADR_STAT, 32'h0, 4'h0);
    chk(rd[15:8], 32'h55);
    $display("test port_a done");
    wb(1'b1, ADR_MODE, 32'he0, 4'hf);
    run <= 1'b1;
    pend <= 1'b1;
    b1 <= 1'b0;
    idle(40);
    chk(cts, 32'h0);
    wb(1'b1, ADR_STAT, 32'h0c, 4'h1);
    cd_n <= 1'b0;
    cts_n <= 1'b0;
    idle(60);
    chk({car, cts}, 32'h3);
    wb(1'b0, ADR_STAT, 32'h0, 4'h0);
    chk(rd[3:2], 32'h3);
    wb(1'b1, ADR_STAT, 32'h0c, 4'h1);
    wb(1'b0, ADR_STAT, 32'h0, 4'h0);
    chk(rd[3:2], 32'h0);
    wb(1'b1, ADR_MODE, 32'h0, 4'hf);
    cd_n <= 1'b1;
    cts_n <= 1'b1;
    idle(60);
    chk({car, cts}, 32'h1);
    wb(1'b0, ADR_STAT, 32'h0, 4'h0);
    chk(rd[3:0], 32'hf);
    chk(n_abort, 32'h1);
    $display("test events done");
    // Second reset with port A pin 7 high and pin 5 low: no boot, clock select stays low
    @(posedge clk_i);
    rst_i <= 1'b1;
    pa_ext <= 8'h80;
    run <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    idle(110);
    chk({dut.boot_serial_o, dut.boot_clk_sel_o}, 2'b00);
    $display("test boot_off done");
    final_report();
  end
endmodule
